// [verilog/mcu_alu_params.svh]
// Constants of the 8-bit core arithmetic unit: opcodes, timing, flags
// Included by the package; holds definitions only
// Behaviour
// - 8-bit add with and without carry
// - 8-bit multiply and divide, five cycles
// - Subtract with borrow, AND, OR, XOR, NOT
// - Multiply and divide operands treated as unsigned; add and subtract overflow flag is signed
// - Increment or decrement main, bank register or direct location
// - Rotate, swap, clear, complement, adjust: main only
// - Operands from main, second, bank register or outside
// - Carry, overflow, parity kept in status word
// - Legacy encodings and results kept
// - Add timing: bank 1, others 2
// - Add with carry timing: bank 1, others 2
// - Subtract with borrow timing: bank 1, others 2
// - Increment timing 1, 2 or 3
// - Decrement timing 1, 2 or 3
// - AND timing 1, 2, 3 or 4
// - OR timing 1, 2, 3 or 4
// - XOR timing 1, 2, 3 or 4
// - Single-operand main register ops take 1 cycle
// - Moves into main register: 1 or 2
// - Moves into bank register: 2 or 4
// - Moves into direct location: 3 or 4
// - One cycle equals one clock
`ifndef MCU_ALU_PARAMS_SVH
`define MCU_ALU_PARAMS_SVH
// Status word bit positions
`define ST_CY 7
`define ST_AC 6
`define ST_OV 2
`define ST_P 0
// Opcode high nibbles of the families
`define HI_INC 4'h0
`define HI_DEC 4'h1
`define HI_ADD 4'h2
`define HI_ADDC 4'h3
`define HI_OR 4'h4
`define HI_AND 4'h5
`define HI_XOR 4'h6
`define HI_MOVI 4'h7
`define HI_MOVD 4'h8
`define HI_SUB 4'h9
`define HI_MOVR 4'hA
`define HI_MOVA 4'hE
`define HI_MOVS 4'hF
// Opcode low nibbles
`define LO_TODIR 4'h2
`define LO_IMMDIR 4'h3
`define LO_IMM 4'h4
`define LO_DIR 4'h5
// Full opcodes
`define OP_INC_DP 8'hA3
`define OP_MUL 8'hA4
`define OP_DIV 8'h84
`define OP_DA 8'hD4
`define OP_SWAP 8'hC4
`define OP_DEC_DIR 8'h15
`define OP_AND_IMMDIR 8'h53
// Cycle counts
`define CYC_ONE 3'd1
`define CYC_TWO 3'd2
`define CYC_THREE 3'd3
`define CYC_FOUR 3'd4
`define CYC_MULDIV 3'd5
// Arithmetic constants
`define INC_STEP 8'h01
`define DP_STEP 16'h0001
`define DA_LIM 4'h9
`define DA_LO 9'h006
`define DA_HI 9'h060
`define DIV0_RES 8'hFF
`endif

// [verilog/mcu_alu_pkg.sv]
// Types shared by the arithmetic unit modules
// Assumes the constants header sits beside it
`include "mcu_alu_params.svh"
package mcu_alu_pkg;
	// Operation performed
	typedef enum logic [4:0] {K_NOP, K_ADD, K_ADDC, K_SUB, K_AND, K_OR, K_XOR, K_INC,
		K_DEC, K_MUL, K_DIV, K_CLR, K_CPL, K_RL, K_RLC, K_RR, K_RRC, K_SWAP, K_DA,
		K_MOV, K_INCDP} alu_kind_t;
	// Operand source
	typedef enum logic [2:0] {S_MAIN, S_B, S_BANK, S_MEM, S_IMM} sel_t;
	// Result destination
	typedef enum logic [2:0] {D_NONE, D_MAIN, D_BANK, D_MEM, D_DP, D_AB} dst_t;
	// Sequencer phase
	typedef enum logic {PH_IDLE, PH_BUSY} phase_t;
	// Decoded instruction
	typedef struct packed {
		alu_kind_t kind;
		sel_t asel;
		sel_t bsel;
		dst_t dst;
		logic [2:0] cyc;
	} dec_t;
	// Request from the core
	typedef struct packed {
		logic valid;
		logic [7:0] opcode;
		logic [7:0] imm;
		logic [7:0] mem;
	} req_t;
	// Completion and memory write-back
	typedef struct packed {
		logic done;
		logic mem_we;
		logic [7:0] mem_wdata;
	} rsp_t;
	// Architectural registers seen by the core
	typedef struct packed {
		logic [7:0] acc;
		logic [7:0] b;
		logic [7:0] program_status_word;
		logic [15:0] data_pointer_reg;
		logic [7:0] ptr0;
		logic [7:0] ptr1;
	} view_t;
	// Byte operation result
	typedef struct packed {
		logic [7:0] res;
		logic cy;
		logic ac;
		logic ov;
		logic wr_cy;
		logic wr_all;
	} alu_out_t;
	// Multiply or divide result
	typedef struct packed {
		logic [7:0] lo;
		logic [7:0] hi;
		logic ov;
	} md_out_t;
	// Whole unit state
	typedef struct packed {
		phase_t phase;
		logic [2:0] cnt;
		dec_t hop;
		logic [2:0] hidx;
		logic [7:0] himm;
		logic [7:0] hmem;
		logic [7:0] acc;
		logic [7:0] b;
		logic [7:0] program_status_word;
		logic [7:0][7:0] bank;
		logic [15:0] data_pointer_reg;
		logic done;
		logic mem_we;
		logic [7:0] mem_wdata;
	} state_t;
endpackage

// [verilog/mcu_alu_core.sv]
// Combinational byte operations with flag results
// Assumes the caller picks operands and commits the result
`timescale 1ns/1ps
module mcu_alu_core (
	input wire mcu_alu_pkg::alu_kind_t kind,
	input wire logic [7:0] a,
	input wire logic [7:0] bv,
	input wire logic cy_in,
	input wire logic ac_in,
	output mcu_alu_pkg::alu_out_t out
);
	import mcu_alu_pkg::*;
	logic sub; // Borrow form
	logic cin; // Carry into bit 0
	logic [7:0] bx; // Second operand, inverted on subtract
	logic [8:0] sum; // Full sum with carry out
	logic [4:0] lo; // Low nibble sum for aux carry
	logic [8:0] da; // Decimal adjusted value
	// Adder, decimal adjust and result select
	always_comb begin
		sub = (kind == K_SUB);
		bx = sub ? ~bv : bv;
		cin = (kind == K_ADDC) ? cy_in : (sub ? ~cy_in : 1'b0);
		sum = {1'b0, a} + {1'b0, bx} + {8'h00, cin};
		lo = {1'b0, a[3:0]} + {1'b0, bx[3:0]} + {4'h0, cin};
		da = {1'b0, a};
		if (a[3:0] > `DA_LIM || ac_in) begin
			da = da + `DA_LO;
		end
		if (da[7:4] > `DA_LIM || cy_in || da[8]) begin
			da = da + `DA_HI;
		end
		out = '0;
		out.res = a;
		out.cy = cy_in;
		out.ac = ac_in;
		case (kind)
			// Add, add with carry, subtract with borrow
			K_ADD, K_ADDC, K_SUB: begin
				out.res = sum[7:0];
				out.cy = sum[8] ^ sub;
				out.ac = lo[4] ^ sub;
				out.ov = (a[7] == bx[7]) && (sum[7] != a[7]);
				out.wr_cy = 1'b1;
				out.wr_all = 1'b1;
			end
			K_AND: out.res = a & bv;
			K_OR: out.res = a | bv;
			K_XOR: out.res = a ^ bv;
			K_INC: out.res = a + `INC_STEP;
			K_DEC: out.res = a - `INC_STEP;
			K_CLR: out.res = '0;
			K_CPL: out.res = ~a;
			K_RL: out.res = {a[6:0], a[7]};
			K_RR: out.res = {a[0], a[7:1]};
			// Rotates through carry
			K_RLC: begin
				out.res = {a[6:0], cy_in};
				out.cy = a[7];
				out.wr_cy = 1'b1;
			end
			K_RRC: begin
				out.res = {cy_in, a[7:1]};
				out.cy = a[0];
				out.wr_cy = 1'b1;
			end
			K_SWAP: out.res = {a[3:0], a[7:4]};
			// Decimal adjust keeps a set carry
			K_DA: begin
				out.res = da[7:0];
				out.cy = cy_in | da[8];
				out.wr_cy = 1'b1;
			end
			K_MOV: out.res = bv;
			default: out.res = a;
		endcase
	end
endmodule

// [verilog/mcu_alu_muldiv.sv]
// Unsigned 8x8 multiply and 8/8 divide
// Assumes the caller holds operands for the instruction length
`timescale 1ns/1ps
module mcu_alu_muldiv (
	input wire logic [7:0] a,
	input wire logic [7:0] bv,
	input wire logic div,
	output mcu_alu_pkg::md_out_t out
);
	import mcu_alu_pkg::*;
	logic [15:0] prod; // Full product
	// Divide by zero gives a fixed pattern and overflow
	always_comb begin
		prod = {8'h00, a} * {8'h00, bv};
		out.lo = prod[7:0];
		out.hi = prod[15:8];
		out.ov = |prod[15:8];
		if (div) begin
			out.ov = (bv == '0);
			out.lo = out.ov ? `DIV0_RES : a / bv;
			out.hi = out.ov ? `DIV0_RES : a % bv;
		end
	end
endmodule

// [verilog/mcu_alu_unit.sv]
// Arithmetic unit of the 8-bit core with instruction cycle timing
// Assumes the core gives opcode, immediate and memory byte with valid
`timescale 1ns/1ps
module mcu_alu_unit (
	input wire logic clk,
	input wire logic sys_rst,
	input wire mcu_alu_pkg::req_t req,
	output logic ready,
	output mcu_alu_pkg::rsp_t rsp,
	output mcu_alu_pkg::view_t view
);
	import mcu_alu_pkg::*;

	state_t st; // Registered state
	state_t next_st; // Next state
	dec_t dec_in; // Decode of incoming opcode
	dec_t dx; // Instruction in execution
	logic [2:0] x_idx; // Bank register index
	logic [7:0] x_imm; // Immediate in execution
	logic [7:0] x_mem; // Memory byte in execution
	logic [7:0] av; // First operand
	logic [7:0] bv; // Second operand
	logic accept; // Request taken
	logic commit; // Result written this edge
	alu_out_t alu; // Byte operation result
	md_out_t md; // Multiply or divide result

	// Build one decode entry
	function automatic dec_t mk(input alu_kind_t k, input sel_t a, input sel_t b,
		input dst_t d, input logic [2:0] c);
		dec_t r;
		r.kind = k;
		r.asel = a;
		r.bsel = b;
		r.dst = d;
		r.cyc = c;
		return r;
	endfunction

	// Operand multiplexer
	function automatic logic [7:0] pick(input sel_t s, input logic [7:0] acc_v,
		input logic [7:0] b_v, input logic [7:0] bank_v, input logic [7:0] mem_v,
		input logic [7:0] imm_v);
		case (s)
			S_MAIN: return acc_v;
			S_B: return b_v;
			S_BANK: return bank_v;
			S_MEM: return mem_v;
			default: return imm_v;
		endcase
	endfunction

	// Opcode to operation, operands, destination and length
	function automatic dec_t decode(input logic [7:0] op);
		dec_t d;
		alu_kind_t k;
		logic [3:0] lo;
		lo = op[3:0];
		d = mk(K_NOP, S_MAIN, S_MAIN, D_NONE, `CYC_ONE);
		k = K_NOP;
		case (op[7:4])
			// Two-operand families into the main register or a direct location; rotate left
			`HI_ADD, `HI_ADDC, `HI_SUB, `HI_AND, `HI_OR, `HI_XOR: begin
				case (op[7:4])
					`HI_ADD: k = K_ADD;
					`HI_ADDC: k = K_ADDC;
					`HI_SUB: k = K_SUB;
					`HI_AND: k = K_AND;
					`HI_OR: k = K_OR;
					default: k = K_XOR;
				endcase
				if (op[3]) begin
					d = mk(k, S_MAIN, S_BANK, D_MAIN, `CYC_ONE);
				end else if (lo == `LO_IMM) begin
					d = mk(k, S_MAIN, S_IMM, D_MAIN, `CYC_TWO);
				end else if (lo >= `LO_DIR) begin
					d = mk(k, S_MAIN, S_MEM, D_MAIN, `CYC_TWO);
				end else if (k == K_AND || k == K_OR || k == K_XOR) begin
					if (lo == `LO_TODIR) begin
						d = mk(k, S_MEM, S_MAIN, D_MEM, `CYC_THREE);
					end else if (lo == `LO_IMMDIR) begin
						d = mk(k, S_MEM, S_IMM, D_MEM, `CYC_FOUR);
					end
				end else if (lo == `LO_IMMDIR && k == K_ADD) begin
					d = mk(K_RL, S_MAIN, S_MAIN, D_MAIN, `CYC_ONE);
				end else if (lo == `LO_IMMDIR && k == K_ADDC) begin
					d = mk(K_RLC, S_MAIN, S_MAIN, D_MAIN, `CYC_ONE);
				end
			end
			// Increment and decrement of main, bank register or direct location; rotate right
			`HI_INC, `HI_DEC: begin
				k = op[4] ? K_DEC : K_INC;
				if (op[3]) begin
					d = mk(k, S_BANK, S_MAIN, D_BANK, `CYC_TWO);
				end else if (lo == `LO_IMM) begin
					d = mk(k, S_MAIN, S_MAIN, D_MAIN, `CYC_ONE);
				end else if (lo >= `LO_DIR) begin
					d = mk(k, S_MEM, S_MAIN, D_MEM, `CYC_THREE);
				end else if (lo == `LO_IMMDIR) begin
					d = mk(op[4] ? K_RRC : K_RR, S_MAIN, S_MAIN, D_MAIN, `CYC_ONE);
				end
			end
			// Moves into the main register, clear
			`HI_MOVA: begin
				if (op[3]) begin
					d = mk(K_MOV, S_MAIN, S_BANK, D_MAIN, `CYC_ONE);
				end else if (lo == `LO_IMM) begin
					d = mk(K_CLR, S_MAIN, S_MAIN, D_MAIN, `CYC_ONE);
				end else if (lo >= `LO_DIR) begin
					d = mk(K_MOV, S_MAIN, S_MEM, D_MAIN, `CYC_TWO);
				end
			end
			// Moves from the main register, complement
			`HI_MOVS: begin
				if (op[3]) begin
					d = mk(K_MOV, S_MAIN, S_MAIN, D_BANK, `CYC_TWO);
				end else if (lo == `LO_IMM) begin
					d = mk(K_CPL, S_MAIN, S_MAIN, D_MAIN, `CYC_ONE);
				end else if (lo == `LO_DIR) begin
					d = mk(K_MOV, S_MAIN, S_MAIN, D_MEM, `CYC_THREE);
				end
			end
			// Immediate moves
			`HI_MOVI: begin
				if (op[3]) begin
					d = mk(K_MOV, S_MAIN, S_IMM, D_BANK, `CYC_TWO);
				end else if (lo == `LO_IMM) begin
					d = mk(K_MOV, S_MAIN, S_IMM, D_MAIN, `CYC_TWO);
				end
			end
			// Direct into bank, data pointer, multiply
			`HI_MOVR: begin
				if (op[3]) begin
					d = mk(K_MOV, S_MAIN, S_MEM, D_BANK, `CYC_FOUR);
				end else if (op == `OP_INC_DP) begin
					d = mk(K_INCDP, S_MAIN, S_MAIN, D_DP, `CYC_ONE);
				end else if (op == `OP_MUL) begin
					d = mk(K_MUL, S_MAIN, S_B, D_AB, `CYC_MULDIV);
				end
			end
			// Moves into direct locations, divide
			`HI_MOVD: begin
				if (op[3]) begin
					d = mk(K_MOV, S_MAIN, S_BANK, D_MEM, `CYC_THREE);
				end else if (lo >= `LO_DIR) begin
					d = mk(K_MOV, S_MAIN, S_MEM, D_MEM, `CYC_FOUR);
				end else if (op == `OP_DIV) begin
					d = mk(K_DIV, S_MAIN, S_B, D_AB, `CYC_MULDIV);
				end
			end
			// Swap and decimal adjust
			default: begin
				if (op == `OP_SWAP) begin
					d = mk(K_SWAP, S_MAIN, S_MAIN, D_MAIN, `CYC_ONE);
				end else if (op == `OP_DA) begin
					d = mk(K_DA, S_MAIN, S_MAIN, D_MAIN, `CYC_ONE);
				end
			end
		endcase
		return d;
	endfunction

	// Handshake: one instruction at a time
	assign ready = (st.phase == PH_IDLE);
	assign accept = req.valid && ready;
	assign dec_in = decode(req.opcode);

	// Execute from the request when idle, else from the held copy
	always_comb begin
		if (st.phase == PH_IDLE) begin
			dx = dec_in;
			x_idx = req.opcode[2:0];
			x_imm = req.imm;
			x_mem = req.mem;
		end else begin
			dx = st.hop;
			x_idx = st.hidx;
			x_imm = st.himm;
			x_mem = st.hmem;
		end
	end

	// Operands from main, second, bank register or outside
	assign av = pick(dx.asel, st.acc, st.b, st.bank[x_idx], x_mem, x_imm);
	assign bv = pick(dx.bsel, st.acc, st.b, st.bank[x_idx], x_mem, x_imm);

	// Commit on the last clock of the instruction
	assign commit = (accept && dec_in.cyc == `CYC_ONE) ||
		(st.phase == PH_BUSY && st.cnt == `CYC_ONE);

	mcu_alu_core i_mcu_alu_core (
		.kind(dx.kind),
		.a(av),
		.bv(bv),
		.cy_in(st.program_status_word[`ST_CY]),
		.ac_in(st.program_status_word[`ST_AC]),
		.out(alu)
	);

	mcu_alu_muldiv i_mcu_alu_muldiv (
		.a(av),
		.bv(bv),
		.div(dx.kind == K_DIV),
		.out(md)
	);

	// Next state: sequencer, write-back and flags
	always_comb begin
		next_st = st;
		next_st.done = 1'b0;
		next_st.mem_we = 1'b0;
		// Hold a multi-cycle instruction
		if (accept && dec_in.cyc != `CYC_ONE) begin
			next_st.phase = PH_BUSY;
			next_st.cnt = dec_in.cyc - `CYC_ONE;
			next_st.hop = dec_in;
			next_st.hidx = req.opcode[2:0];
			next_st.himm = req.imm;
			next_st.hmem = req.mem;
		end
		// One count per clock
		if (st.phase == PH_BUSY) begin
			next_st.cnt = st.cnt - `CYC_ONE;
			if (st.cnt == `CYC_ONE) begin
				next_st.phase = PH_IDLE;
			end
		end
		if (commit) begin
			next_st.done = 1'b1;
			case (dx.dst)
				D_MAIN: next_st.acc = alu.res;
				D_BANK: next_st.bank[x_idx] = alu.res;
				// Result driven out of the unit
				D_MEM: begin
					next_st.mem_we = 1'b1;
					next_st.mem_wdata = alu.res;
				end
				D_DP: next_st.data_pointer_reg = st.data_pointer_reg + `DP_STEP;
				D_AB: begin
					next_st.acc = md.lo;
					next_st.b = md.hi;
				end
				default: next_st.done = 1'b1;
			endcase
			// Flags into the status word
			if (dx.kind == K_MUL || dx.kind == K_DIV) begin
				next_st.program_status_word[`ST_CY] = 1'b0;
				next_st.program_status_word[`ST_OV] = md.ov;
			end else begin
				if (alu.wr_cy) begin
					next_st.program_status_word[`ST_CY] = alu.cy;
				end
				if (alu.wr_all) begin
					next_st.program_status_word[`ST_AC] = alu.ac;
					next_st.program_status_word[`ST_OV] = alu.ov;
				end
			end
		end
		next_st.program_status_word[`ST_P] = ^next_st.acc;
	end

	// State register, synchronous reset
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// Outputs straight from flip-flops
	assign rsp = {st.done, st.mem_we, st.mem_wdata};
	assign view = {st.acc, st.b, st.program_status_word, st.data_pointer_reg, st.bank[0], st.bank[1]};

	// Reference values captured at acceptance
	logic [15:0] h_mul;
	logic [7:0] h_add;
	logic [7:0] h_addc;
	logic h_brw;
	logic [2:0] h_idx;
	logic [7:0] h_inc;
	logic [7:0] h_dec;
	logic [7:0] h_and;
	logic [7:0] h_swap;
	assign h_mul = {8'h00, st.acc} * {8'h00, st.b};
	assign h_add = 8'(st.acc + st.bank[req.opcode[2:0]]);
	assign h_addc = 8'(st.acc + req.imm + {7'h00, st.program_status_word[`ST_CY]});
	assign h_brw = {1'b0, st.acc} < ({1'b0, st.bank[req.opcode[2:0]]} +
		{8'h00, st.program_status_word[`ST_CY]});
	assign h_idx = req.opcode[2:0];
	assign h_inc = 8'(st.bank[h_idx] + `INC_STEP);
	assign h_dec = 8'(req.mem - `INC_STEP);
	assign h_and = req.mem & req.imm;
	assign h_swap = {st.acc[3:0], st.acc[7:4]};

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	property p_mul_time;
		accept && req.opcode == `OP_MUL |=> !ready [*4] ##1 ready;
	endproperty
	a_mul_time: assert property (p_mul_time) else $error("multiply length wrong");
	property p_mul_res;
		accept && req.opcode == `OP_MUL |-> ##5 rsp.done && view.acc == $past(h_mul[7:0], 5)
			&& view.b == $past(h_mul[15:8], 5);
	endproperty
	a_mul_res: assert property (p_mul_res) else $error("multiply result wrong");
	property p_add_rn;
		accept && dec_in.kind == K_ADD && dec_in.bsel == S_BANK |=>
			ready && rsp.done && view.acc == $past(h_add);
	endproperty
	a_add_rn: assert property (p_add_rn) else $error("bank add wrong");
	property p_addc_imm;
		accept && dec_in.kind == K_ADDC && dec_in.bsel == S_IMM |=>
			!ready ##1 ready && view.acc == $past(h_addc, 2);
	endproperty
	a_addc_imm: assert property (p_addc_imm) else $error("immediate addc wrong");
	property p_subtract_with_borrow_cy;
		accept && dec_in.kind == K_SUB && dec_in.bsel == S_BANK |=>
			view.program_status_word[`ST_CY] == $past(h_brw);
	endproperty
	a_subtract_with_borrow_cy: assert property (p_subtract_with_borrow_cy) else $error("borrow wrong");
	property p_inc_rn;
		accept && dec_in.kind == K_INC && dec_in.asel == S_BANK |-> ##2
			rsp.done && st.bank[$past(h_idx, 2)] == $past(h_inc, 2);
	endproperty
	a_inc_rn: assert property (p_inc_rn) else $error("bank increment wrong");
	property p_dec_dir;
		accept && req.opcode == `OP_DEC_DIR |-> ##3
			rsp.mem_we && rsp.mem_wdata == $past(h_dec, 3);
	endproperty
	a_dec_dir: assert property (p_dec_dir) else $error("direct decrement wrong");
	property p_anl_immdir;
		accept && req.opcode == `OP_AND_IMMDIR |=> !rsp.done [*3] ##1
			rsp.mem_we && rsp.mem_wdata == $past(h_and, 4);
	endproperty
	a_anl_immdir: assert property (p_anl_immdir) else $error("and to direct wrong");
	property p_swap;
		accept && req.opcode == `OP_SWAP |=> ready && view.acc == $past(h_swap);
	endproperty
	a_swap: assert property (p_swap) else $error("swap wrong");
	property p_parity;
		rsp.done |-> view.program_status_word[`ST_P] == ^view.acc;
	endproperty
	a_parity: assert property (p_parity) else $error("parity flag wrong");
	property p_mov_rn_dir;
		accept && dec_in.dst == D_BANK && dec_in.bsel == S_MEM |=> !ready [*3] ##1 ready;
	endproperty
	a_mov_rn_dir: assert property (p_mov_rn_dir) else $error("move length wrong");

	c_mul: cover property (accept && req.opcode == `OP_MUL ##5 rsp.done);
	c_div: cover property (accept && req.opcode == `OP_DIV ##5 rsp.done);
	c_b2b: cover property (accept ##1 accept ##1 accept);
	c_and: cover property (accept && req.opcode == `OP_AND_IMMDIR ##4 rsp.mem_we);
endmodule

// [bench/mcu_alu_unit_tb.sv]
// Self-checking bench for the arithmetic unit: timing, results, flags
// Assumes the unit package and header are compiled first
`timescale 1ns/1ps
`define CHK(nm, e, g) chk(nm, 16'(e), 16'(g))
module mcu_alu_unit_tb;
	import mcu_alu_pkg::*;
	logic clk = 1'b0; // Core clock
	logic sys_rst = 1'b1; // Sync reset
	req_t req = '0; // Request to the unit
	logic ready; // Unit idle
	rsp_t rsp; // Completion
	view_t view; // Visible registers
	int n_fail = 0; // Mismatches
	int checked = 0; // Comparisons
	int cycles = 0; // Watchdog count
	logic [7:0] ma; // Model accumulator
	logic mc; // Model carry
	logic [7:0] ops [7] = '{8'h23, 8'h33, 8'h03, 8'h13, 8'hC4, 8'hF4, 8'hE4}; // Acc-only ops

	// Clock of 5 ns
	always #2.5 clk = ~clk;

	mcu_alu_unit i_mcu_alu_unit (
		.clk(clk),
		.sys_rst(sys_rst),
		.req(req),
		.ready(ready),
		.rsp(rsp),
		.view(view)
	);

	// Compare and count
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		checked++;
		if (g !== e) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Verdict and end of run
	task automatic results();
		$display("checked %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// Watchdog against a hang
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			n_fail++;
			results();
		end
	end

	// One instruction; returns in the cycle where done is high
	task automatic run(input logic [7:0] op, input logic [7:0] im, input logic [7:0] mm,
		input int cyc);
		int n;
		n = 0;
		@(posedge clk);
		req <= '{valid: 1'b1, opcode: op, imm: im, mem: mm};
		@(posedge clk);
		req <= '0;
		do begin
			@(negedge clk);
			n++;
			if (n == 1 && cyc > 1) begin
				`CHK("ready_busy", 0, ready);
			end
		end while (rsp.done !== 1'b1 && n < 20);
		`CHK("cycles", cyc, n);
	endtask

	// Values after reset
	task automatic t_reset();
		`CHK("acc", 0, view.acc);
		`CHK("psw", 0, view.program_status_word);
		`CHK("ready", 1, ready);
	endtask

	// Add, add with carry, subtract with borrow
	task automatic t_arith();
		run(8'h74, 8'h5A, 8'h00, 2);
		run(8'h24, 8'hC0, 8'h00, 2);
		`CHK("acc", 8'h1A, view.acc);
		`CHK("cy", 1, view.program_status_word[7]);
		`CHK("ov", 0, view.program_status_word[2]);
		`CHK("par", ^8'h1A, view.program_status_word[0]);
		run(8'h34, 8'h05, 8'h00, 2);
		`CHK("acc", 8'h20, view.acc);
		run(8'h94, 8'h21, 8'h00, 2);
		`CHK("acc", 8'hFF, view.acc);
		`CHK("cy", 1, view.program_status_word[7]);
		run(8'h94, 8'h7F, 8'h00, 2);
		`CHK("acc", 8'h7F, view.acc);
		`CHK("ov", 1, view.program_status_word[2]);
	endtask

	// Logic ops into acc and to direct
	task automatic t_logic();
		run(8'h54, 8'h3C, 8'h00, 2);
		run(8'h44, 8'hC1, 8'h00, 2);
		run(8'h64, 8'h0F, 8'h00, 2);
		`CHK("acc", 8'hF2, view.acc);
		run(8'h53, 8'h0F, 8'hA5, 4);
		`CHK("we", 1, rsp.mem_we);
		`CHK("wdata", 8'h05, rsp.mem_wdata);
		run(8'h42, 8'h00, 8'h0F, 3);
		`CHK("wdata", 8'hFF, rsp.mem_wdata);
		run(8'h63, 8'hFF, 8'h3C, 4);
		`CHK("wdata", 8'hC3, rsp.mem_wdata);
		`CHK("acc", 8'hF2, view.acc);
	endtask

	// Increment and decrement of every kind
	task automatic t_incdec();
		run(8'h04, 8'h00, 8'h00, 1);
		run(8'h14, 8'h00, 8'h00, 1);
		`CHK("acc", 8'hF2, view.acc);
		run(8'hA3, 8'h00, 8'h00, 1);
		`CHK("data_pointer_reg", 16'h0001, view.data_pointer_reg);
		run(8'h08, 8'h00, 8'h00, 2);
		`CHK("r0", 8'h01, view.ptr0);
		run(8'h19, 8'h00, 8'h00, 2);
		`CHK("r1", 8'hFF, view.ptr1);
		run(8'h05, 8'h00, 8'hFF, 3);
		`CHK("wdata", 8'h00, rsp.mem_wdata);
		run(8'h15, 8'h00, 8'h00, 3);
		`CHK("wdata", 8'hFF, rsp.mem_wdata);
		run(8'h16, 8'h00, 8'h80, 3);
		`CHK("wdata", 8'h7F, rsp.mem_wdata);
	endtask

	// Multiply and divide, divide by zero included
	task automatic t_muldiv();
		run(8'h84, 8'h00, 8'h00, 5);
		`CHK("ab", 16'hFFFF, {view.acc, view.b});
		run(8'hA4, 8'h00, 8'h00, 5);
		`CHK("ab", 16'h01FE, {view.acc, view.b});
		`CHK("ov", 1, view.program_status_word[2]);
		run(8'h84, 8'h00, 8'h00, 5);
		`CHK("ab", 16'h0001, {view.acc, view.b});
		run(8'h74, 8'hC8, 8'h00, 2);
		run(8'h84, 8'h00, 8'h00, 5);
		`CHK("ab", 16'hC800, {view.acc, view.b});
	endtask

	// Accumulator-only ops against a running model
	task automatic t_accops();
		run(8'h74, 8'hFF, 8'h00, 2);
		run(8'h24, 8'h01, 8'h00, 2);
		run(8'h74, 8'h96, 8'h00, 2);
		ma = 8'h96;
		mc = 1'b1;
		foreach (ops[i]) begin
			case (ops[i])
				8'h23: ma = {ma[6:0], ma[7]};
				8'h33: {mc, ma} = {ma, mc};
				8'h03: ma = {ma[0], ma[7:1]};
				8'h13: {ma, mc} = {mc, ma};
				8'hC4: ma = {ma[3:0], ma[7:4]};
				8'hF4: ma = ~ma;
				default: ma = 8'h00;
			endcase
			run(ops[i], 8'h00, 8'h00, 1);
			`CHK("acc", ma, view.acc);
			`CHK("cy", mc, view.program_status_word[7]);
		end
		run(8'h74, 8'h38, 8'h00, 2);
		run(8'h24, 8'h25, 8'h00, 2);
		run(8'hD4, 8'h00, 8'h00, 1);
		`CHK("acc", 8'h63, view.acc);
	endtask

	// Moves, bank registers and bank forms of the arithmetic
	task automatic t_moves();
		run(8'h7A, 8'h33, 8'h00, 2);
		run(8'hEA, 8'h00, 8'h00, 1);
		`CHK("acc", 8'h33, view.acc);
		run(8'hF9, 8'h00, 8'h00, 2);
		`CHK("r1", 8'h33, view.ptr1);
		run(8'hA8, 8'h00, 8'h5C, 4);
		`CHK("r0", 8'h5C, view.ptr0);
		run(8'hF5, 8'h00, 8'h00, 3);
		`CHK("wdata", 8'h33, rsp.mem_wdata);
		run(8'h85, 8'h00, 8'h6E, 4);
		`CHK("wdata", 8'h6E, rsp.mem_wdata);
		run(8'h87, 8'h00, 8'h71, 4);
		`CHK("wdata", 8'h71, rsp.mem_wdata);
		run(8'h89, 8'h00, 8'h00, 3);
		`CHK("wdata", 8'h33, rsp.mem_wdata);
		run(8'hE6, 8'h00, 8'h44, 2);
		run(8'h29, 8'h00, 8'h00, 1);
		`CHK("acc", 8'h77, view.acc);
		run(8'h3A, 8'h00, 8'h00, 1);
		`CHK("acc", 8'hAA, view.acc);
		run(8'h9A, 8'h00, 8'h00, 1);
		`CHK("acc", 8'h77, view.acc);
		run(8'h5A, 8'h00, 8'h00, 1);
		run(8'h4A, 8'h00, 8'h00, 1);
		run(8'h6A, 8'h00, 8'h00, 1);
		`CHK("acc", 8'h00, view.acc);
	endtask

	// Back-to-back single-cycle ops, then an opcode outside the unit
	task automatic t_b2b();
		@(posedge clk);
		req <= '{valid: 1'b1, opcode: 8'h04, imm: 8'h00, mem: 8'h00};
		@(posedge clk);
		@(posedge clk);
		req <= '0;
		@(negedge clk);
		`CHK("done", 1, rsp.done);
		`CHK("acc", 8'h02, view.acc);
		run(8'h80, 8'h00, 8'h00, 1);
		`CHK("acc", 8'h02, view.acc);
	endtask

	// Main sequence
	initial begin
		repeat (6) @(posedge clk);
		sys_rst <= 1'b0;
		@(negedge clk);
		t_reset();
		t_arith();
		t_logic();
		t_incdec();
		t_muldiv();
		t_accops();
		t_moves();
		t_b2b();
		results();
	end
endmodule
